// *** rtl/branch_cfg.svh ***
/*
 Constants for the conditional relative-branch unit: opcode patterns,
 last phase number, program counter width, reset value and step.
 Assumes every file that uses these constants includes it by bare name.
*/
`ifndef BRANCH_CFG_SVH
`define BRANCH_CFG_SVH
`define BRANCH_NOT_ZERO_OP     8'hE1
`define BRANCH_NO_OVERFLOW_OP  8'hE5
`define PC_W           21
`define PC_RST         21'h000000
`define PC_STEP        21'h000002
`define PHASE_LAST     2'h3
`endif

// *** rtl/branch_decode.sv ***
/*
 Combinational decode of the two conditional branches.
 Assumes flags come from the status register on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "branch_cfg.svh"
module branch_decode (
   input  wire logic [15:0]         instr_i,
   input  wire logic [`PC_W-1:0]    addr_i,
   input  wire logic                zero_i,
   input  wire logic                ovf_i,
   output branch_pkg::decode_t      dec_o
);
   function automatic logic [`PC_W-1:0] rel_target(input logic [`PC_W-1:0] a, input logic [7:0] n);
      logic [`PC_W-1:0] ext;
      ext = {{(`PC_W-9){n[7]}}, n, 1'b0};
      return a + `PC_STEP + ext;
   endfunction

   logic is_nz;
   logic is_nov;
   assign is_nz  = instr_i[15:8] == `BRANCH_NOT_ZERO_OP;
   assign is_nov = instr_i[15:8] == `BRANCH_NO_OVERFLOW_OP;
   always_comb begin
      dec_o.is_branch = is_nz | is_nov;
      dec_o.taken     = (is_nz & ~zero_i) | (is_nov & ~ovf_i);
      dec_o.target    = rel_target(addr_i, instr_i[7:0]);
   end
endmodule
`default_nettype wire

// *** rtl/branch_exec.sv ***
/*
 Four-phase execute stage for the two conditional relative branches.
 Assumes the fetch stage presents the instruction word before Q1 of each
 instruction cycle and holds it through Q4. Other opcodes just advance the
 program counter by one word. Status flags are inputs only.
 A low clock enable stalls every phase, so the fetch stage must keep the
 instruction word and flags steady across a stall.
*/
`timescale 1ns/1ps
`default_nettype none
`include "branch_cfg.svh"
module branch_exec (
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   input  wire logic              en_i,
   input  wire logic [15:0]       instr_i,
   input  wire logic              zero_i,
   input  wire logic              ovf_i,
   output logic [`PC_W-1:0]       pc_o,
   output logic [1:0]             phase_o,
   output logic                   flush_o,
   output logic                   pc_wr_o,
   output logic                   branch_o
);
   branch_pkg::core_state_t s_q;
   branch_pkg::core_state_t s_d;
   branch_pkg::decode_t     dec;

   branch_decode u_dec (
      .instr_i (instr_i),
      .addr_i  (s_q.pc),
      .zero_i  (zero_i),
      .ovf_i   (ovf_i),
      .dec_o   (dec)
   );

   // ----------------------------------------
   // Phase sequencer
   // ----------------------------------------
   always_comb begin
      s_d       = s_q;
      s_d.pc_wr = 1'b0;
      s_d.phase = s_q.phase + 2'h1;
      unique case (s_q.st)
         branch_pkg::ST_EXEC: begin
            unique case (s_q.phase)
               2'h0: begin
                  // Decode: capture own address and operand
                  s_d.own_addr    = s_q.pc;
                  s_d.offset      = instr_i[7:0];
                  s_d.branch_seen = dec.is_branch;
                  s_d.jump        = dec.taken;
               end
               2'h1, 2'h2: begin
               end
               2'h3: begin
                  s_d.pc_wr = 1'b1;
                  if (s_q.jump) begin
                     // Prefetched word is discarded by the extra cycle
                     s_d.pc    = dec.target;
                     s_d.st    = branch_pkg::ST_FLUSH;
                     s_d.flush = 1'b1;
                  end else begin
                     s_d.pc = s_q.pc + `PC_STEP;
                  end
               end
            endcase
         end
         branch_pkg::ST_FLUSH: begin
            if (s_q.phase == `PHASE_LAST) begin
               s_d.st    = branch_pkg::ST_EXEC;
               s_d.flush = 1'b0;
               s_d.jump  = 1'b0;
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Flags are sampled only at Q1; nothing here writes them
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '{st:          branch_pkg::ST_EXEC,
                  phase:       2'h0,
                  pc:          `PC_RST,
                  own_addr:    `PC_RST,
                  offset:      8'h00,
                  jump:        1'b0,
                  flush:       1'b0,
                  pc_wr:       1'b0,
                  branch_seen: 1'b0};
      end else if (en_i) begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign pc_o     = s_q.pc;
   assign phase_o  = s_q.phase;
   assign flush_o  = s_q.flush;
   assign pc_wr_o  = s_q.pc_wr;
   assign branch_o = s_q.branch_seen;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [`PC_W-1:0] exp_tgt;
   assign exp_tgt = s_q.own_addr + `PC_STEP + {{(`PC_W-9){s_q.offset[7]}}, s_q.offset, 1'b0};

   property p_target;
      @(posedge clk_i) disable iff (!rstn_i)
      (en_i && s_q.st == branch_pkg::ST_EXEC && s_q.phase == 2'h3 && s_q.jump) |=> (pc_o == $past(dec.target));
   endproperty
   a_target: assert property (p_target) else $error("taken branch wrong target");

   property p_flush_len;
      @(posedge clk_i) disable iff (!rstn_i)
      ($rose(flush_o) && en_i) ##1 en_i [*3] |-> flush_o ##1 !flush_o;
   endproperty
   a_flush_len: assert property (p_flush_len) else $error("flush cycle wrong length");

   property p_not_taken;
      @(posedge clk_i) disable iff (!rstn_i)
      (en_i && s_q.st == branch_pkg::ST_EXEC && s_q.phase == 2'h3 && !s_q.jump)
         |=> (pc_o == $past(pc_o) + `PC_STEP) && !flush_o;
   endproperty
   a_not_taken: assert property (p_not_taken) else $error("not taken did not advance");

   property p_pc_q4;
      @(posedge clk_i) disable iff (!rstn_i)
      ($past(en_i) && pc_wr_o) |-> $past(s_q.phase) == 2'h3;
   endproperty
   a_pc_q4: assert property (p_pc_q4) else $error("pc written outside Q4");

   property p_nz;
      @(posedge clk_i) disable iff (!rstn_i)
      (en_i && s_q.st == branch_pkg::ST_EXEC && s_q.phase == 2'h0 && instr_i[15:8] == `BRANCH_NOT_ZERO_OP)
         |=> s_q.jump == !$past(zero_i);
   endproperty
   a_nz: assert property (p_nz) else $error("not-zero condition wrong");

   property p_nov;
      @(posedge clk_i) disable iff (!rstn_i)
      (en_i && s_q.st == branch_pkg::ST_EXEC && s_q.phase == 2'h0 && instr_i[15:8] == `BRANCH_NO_OVERFLOW_OP)
         |=> s_q.jump == !$past(ovf_i);
   endproperty
   a_nov: assert property (p_nov) else $error("no-overflow condition wrong");

   property p_other;
      @(posedge clk_i) disable iff (!rstn_i)
      (en_i && s_q.st == branch_pkg::ST_EXEC && s_q.phase == 2'h0 &&
       instr_i[15:8] != `BRANCH_NOT_ZERO_OP && instr_i[15:8] != `BRANCH_NO_OVERFLOW_OP)
         |=> !s_q.jump && !branch_o;
   endproperty
   a_other: assert property (p_other) else $error("non-branch decoded as branch");

   property p_offset;
      @(posedge clk_i) disable iff (!rstn_i)
      (s_q.st == branch_pkg::ST_EXEC && s_q.phase == 2'h3 && s_q.jump) |-> dec.target == exp_tgt;
   endproperty
   a_offset: assert property (p_offset) else $error("offset not doubled and signed");

   property p_phase_step;
      @(posedge clk_i) disable iff (!rstn_i)
      en_i |=> phase_o == $past(phase_o) + 2'h1;
   endproperty
   a_phase_step: assert property (p_phase_step) else $error("phase did not step");

   // A stall must not let a half-done branch slip a phase
   property p_freeze;
      @(posedge clk_i) disable iff (!rstn_i)
      !en_i |=> $stable(s_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while stalled");

   property p_pc_hold;
      @(posedge clk_i) disable iff (!rstn_i)
      (en_i && s_q.st == branch_pkg::ST_EXEC && s_q.phase != 2'h3) |=> $stable(pc_o);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc moved before Q4");

   property p_jump_flush;
      @(posedge clk_i) disable iff (!rstn_i)
      (en_i && s_q.st == branch_pkg::ST_EXEC && s_q.phase == 2'h3 && s_q.jump) |=> flush_o && pc_wr_o;
   endproperty
   a_jump_flush: assert property (p_jump_flush) else $error("taken branch without flush");

   // The prefetched word is dropped, so nothing may move the PC here
   property p_flush_pc;
      @(posedge clk_i) disable iff (!rstn_i)
      (en_i && flush_o) |=> $stable(pc_o);
   endproperty
   a_flush_pc: assert property (p_flush_pc) else $error("pc moved during flush");

   property p_flush_exit;
      @(posedge clk_i) disable iff (!rstn_i)
      (en_i && flush_o && s_q.phase == `PHASE_LAST)
         |=> !flush_o && s_q.st == branch_pkg::ST_EXEC && s_q.phase == 2'h0;
   endproperty
   a_flush_exit: assert property (p_flush_exit) else $error("flush did not end after Q4");

   property p_branch_flag;
      @(posedge clk_i) disable iff (!rstn_i)
      (en_i && s_q.st == branch_pkg::ST_EXEC && s_q.phase == 2'h0 &&
       (instr_i[15:8] == `BRANCH_NOT_ZERO_OP || instr_i[15:8] == `BRANCH_NO_OVERFLOW_OP)) |=> branch_o;
   endproperty
   a_branch_flag: assert property (p_branch_flag) else $error("branch opcode not flagged");

   // ----------------------------------------
   // Coverage
   // ----------------------------------------
   c_taken: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(flush_o));
   c_back: cover property (@(posedge clk_i) disable iff (!rstn_i) pc_wr_o && s_q.offset[7] && s_q.flush);
   c_skip: cover property (@(posedge clk_i) disable iff (!rstn_i) pc_wr_o && branch_o && !flush_o);
   c_stall: cover property (@(posedge clk_i) disable iff (!rstn_i) !en_i && pc_wr_o);
   c_wrap: cover property (@(posedge clk_i) disable iff (!rstn_i) pc_wr_o && $past(en_i) && pc_o < $past(pc_o));
endmodule
`default_nettype wire

// *** rtl/branch_pkg.sv ***
/*
 Types shared by the branch unit: phase numbering, decoded instruction
 and the unit's state. Assumes branch_cfg.svh is visible to users.
*/
`include "branch_cfg.svh"
package branch_pkg;
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
   typedef enum {ST_EXEC, ST_FLUSH} exec_t;
   typedef struct packed {
      logic             is_branch;
      logic             taken;
      logic [`PC_W-1:0] target;
   } decode_t;
   typedef struct packed {
      exec_t            st;
      logic [1:0]       phase;
      logic [`PC_W-1:0] pc;
      logic [`PC_W-1:0] own_addr;
      logic [7:0]       offset;
      logic             jump;
      logic             flush;
      logic             pc_wr;
      logic             branch_seen;
   } core_state_t;
endpackage

// *** test/conditional_branch_exec_tb.sv ***
/*
 Bench for branch_exec with a fetch model.
 Assumes a 10 MHz clock and an async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "branch_cfg.svh"
module conditional_branch_exec_tb;
   logic             clk_i  = 1'b0;
   logic             rstn_i = 1'b0;
   logic             en_i   = 1'b1;
   logic             zero_i = 1'b0;
   logic             ovf_i  = 1'b0;
   logic [15:0]      instr;
   logic [`PC_W-1:0] pc;
   logic [1:0]       phase;
   logic             flush, pc_wr, branch;
   int               miscompares = 0;
   int               n_compared  = 0;
   always #50 clk_i = ~clk_i;
   fetch_model fm_u (.pc_i(pc), .instr_o(instr));
   branch_exec dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en_i),
      .instr_i(instr), .zero_i(zero_i), .ovf_i(ovf_i), .pc_o(pc),
      .phase_o(phase), .flush_o(flush), .pc_wr_o(pc_wr), .branch_o(branch));
   // ----
   // Helpers
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compared=%0d miscompares=%0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask
   // Next edge captures a fresh instruction
   task automatic wait_q1();
      int n = 0;
      while (!(phase === 2'h0 && flush === 1'b0)) begin
         tick();
         n++;
         if (n > 20) begin
            miscompares++;
            give_verdict();
         end
      end
   endtask
   task automatic run_op(input logic [7:0] hi, input logic z, input logic v,
                         input logic [7:0] off, input logic take);
      logic [`PC_W-1:0] own, exp;
      int n;
      wait_q1();
      own = pc;
      exp = own + `PC_STEP + (take ? {{12{off[7]}}, off, 1'b0} : 21'h000000);
      fm_u.mem[own[6:1]] = {hi, off};
      zero_i = z;
      ovf_i = v;
      tick();
      tick();
      check(branch, hi == `BRANCH_NOT_ZERO_OP || hi == `BRANCH_NO_OVERFLOW_OP);
      n = 2;
      while (pc_wr !== 1'b1 && n < 12) begin
         tick();
         n++;
      end
      check(n, 4);
      check(pc, exp);
      check(flush, take);
      fm_u.mem[own[6:1]] = 16'h0000;
      if (take) begin
         repeat (3) begin
            tick();
            check(flush, 1'b1);
         end
         tick();
         check({flush, phase}, 3'h0);
      end
      check(pc, exp);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic sc_reset();
      rstn_i = 1'b0;
      tick();
      check({pc, phase, flush, pc_wr, branch}, 32'h0);
      tick();
      rstn_i = 1'b1;
   endtask
   // Wraps below zero, then flag crossings
   task automatic sc_zero();
      run_op(8'hE1, 1'b0, 1'b1, 8'h80, 1'b1);
      run_op(8'hE1, 1'b1, 1'b0, 8'h7F, 1'b0);
      run_op(8'hE1, 1'b0, 1'b0, 8'h7F, 1'b1);
   endtask
   task automatic sc_ovf();
      run_op(8'hE5, 1'b1, 1'b0, 8'hFF, 1'b1);
      run_op(8'hE5, 1'b0, 1'b1, 8'h01, 1'b0);
   endtask
   task automatic sc_other();
      run_op(8'hE0, 1'b0, 1'b0, 8'h10, 1'b0);
      run_op(8'hE4, 1'b0, 1'b0, 8'h10, 1'b0);
   endtask
   // Stall holds phase and PC frozen
   task automatic sc_stall();
      logic [`PC_W-1:0] held;
      wait_q1();
      held = pc;
      en_i = 1'b0;
      repeat (5) tick();
      check({phase, pc}, {2'h0, held});
      en_i = 1'b1;
      run_op(8'hE1, 1'b0, 1'b0, 8'h04, 1'b1);
   endtask
   initial begin
      sc_reset();
      sc_zero();
      sc_ovf();
      sc_other();
      sc_stall();
      sc_reset();
      run_op(8'hE1, 1'b0, 1'b0, 8'h03, 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire

// *** test/fetch_model.sv ***
/*
 Fetch stage model: hands out the program word at the current PC.
 Assumes the bench loads mem between instructions.
*/
`timescale 1ns/1ps
`default_nettype none
`include "branch_cfg.svh"
module fetch_model (
   input  wire logic [`PC_W-1:0] pc_i,
   output logic      [15:0]      instr_o
);
   logic [15:0] mem [0:63];
   // Empty slots hold a non-branch opcode
   initial for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
   assign instr_o = mem[pc_i[6:1]];
endmodule
`default_nettype wire
